// ### rtl/dyn_mac_table.sv
module dyn_mac_table import switch_lut_pkg::*; #(
	parameter int IDX_W = 10
) (
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic [51:0] daKey,
	input wire logic [51:0] saKey,
	output logic daHit,
	output logic [1:0] daPort,
	output logic saHit,
	input wire logic learnWe,
	input wire logic [1:0] learnPort,
	input wire logic [1:0] learnTs,
	input wire logic [IDX_W-1:0] rdIdx,
	output logic [DYN_ENTRY_W-1:0] rdEntry,
	output logic [IDX_W-1:0] countMinusOne,
	output logic empty
);
	localparam int DEPTH = 1 << IDX_W;
	logic [DYN_ENTRY_W-1:0] mem [DEPTH];
	logic [DEPTH-1:0] validQ;
	logic [IDX_W:0] countQ;
	logic [IDX_W-1:0] daIdx;
	logic [IDX_W-1:0] saIdx;

	// Fold key to an index; direct mapped, a new key evicts an old one
	function automatic logic [IDX_W-1:0] foldKey(input logic [51:0] k);
		logic [IDX_W-1:0] h;
		h = '0;
		for (int i = 0; i < 52; i++) begin
			h[i % IDX_W] = h[i % IDX_W] ^ k[i];
		end
		return h;
	endfunction : foldKey

	assign daIdx = foldKey(daKey);
	assign saIdx = foldKey(saKey);
	assign daHit = validQ[daIdx] && mem[daIdx][51:0] == daKey;
	assign daPort = mem[daIdx][DYN_PORT_LSB +: 2];
	assign saHit = validQ[saIdx] && mem[saIdx][51:0] == saKey;
	assign rdEntry = validQ[rdIdx] ? mem[rdIdx] : '0;
	assign empty = countQ == '0;
	assign countMinusOne = empty ? '0 : IDX_W'(countQ - 1'b1);

	always_ff @(posedge mclk) begin
		if (learnWe) begin
			mem[saIdx] <= {learnTs, learnPort, saKey};
		end
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			validQ <= '0;
			countQ <= '0;
		end else if (learnWe) begin
			validQ[saIdx] <= 1'b1;
			if (!validQ[saIdx]) begin
				countQ <= countQ + 1'b1;
			end
		end
	end
endmodule : dyn_mac_table

// ### rtl/switch_lookup_table_access.sv
// Notes on behaviour
// - Static read returns entry bits 57-0
// - VLAN table used only when mode enabled
// - Sixteen 20-bit VLAN entries, indirectly accessible
// - Entry bit 19 valid, resets to one
// - Bits 18-16 membership, flood on miss
// - Bits 15-12 filter group joins lookup keys
// - Bits 11-0 VLAN id, reset 0x001
// - Untagged or null VID takes port default
// - Invalid VID drops packet, no learning
// - DA miss floods members except ingress
// - SA miss learns key into dynamic table
// - VLAN read: 0x14, index, low data bytes
// - Dynamic table read only, writes ignored
// - Bit 71 not-ready; reread until zero
// - Bit 66 table empty, resets one
// - Count field is valid entries minus one
// - Bits 55-54 aging time stamp
// - Bits 53-52 learned source port
// - Bits 51-48 group id, 47-0 MAC
// - Only address-low write launches command
// - Control bits 3-2 select table
// - Control bit 4: one read, zero write
//
// Decided for this implementation: the placing of the registers and the AXI4-Lite slave port.
module switch_lookup_table_access import switch_lut_pkg::*; #(
	parameter int ADDR_W = 12,
	parameter int DYN_IDX_W = 10,
	parameter int STATIC_N = 8,
	parameter int VLAN_N = 16,
	parameter int AGE_CYCLES = 1000000
) (
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic awvalid,
	input wire logic [ADDR_W-1:0] awaddr,
	output logic awready,
	input wire logic wvalid,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	output logic wready,
	output logic bvalid,
	output logic [1:0] bresp,
	input wire logic bready,
	input wire logic arvalid,
	input wire logic [ADDR_W-1:0] araddr,
	output logic arready,
	output logic rvalid,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	input wire logic rready,
	input wire logic pktValid,
	input wire logic [1:0] pktPort,
	input wire logic pktTagged,
	input wire logic [11:0] pktVid,
	input wire logic [47:0] pktDa,
	input wire logic [47:0] pktSa,
	output logic fwdValid,
	output logic fwdDrop,
	output logic [2:0] fwdPorts
);
	logic [7:0] gcfgQ;
	logic [7:0] ctrl0Q;
	logic [7:0] ctrl1Q;
	logic [11:0] pvidQ [NUM_PORTS];
	logic [DATA_BYTES*8-1:0] dataQ;
	logic [VLAN_W-1:0] vlanQ [VLAN_N];
	logic [STATIC_W-1:0] staticQ [STATIC_N];
	logic awHeldQ;
	logic wHeldQ;
	logic [ADDR_W-1:0] awAddrQ;
	logic [31:0] wDataQ;
	logic [3:0] wStrbQ;
	logic wrDo;
	logic [7:0] wIdx;
	logic wMapped;
	logic [7:0] rIdx;
	logic rMapped;
	logic [31:0] rWord;
	logic trig;
	logic [9:0] cmdAddr;
	table_sel_t cmdSel;
	logic cmdRead;
	logic dynPendQ;
	logic [DYN_IDX_W-1:0] dynIdxQ;
	logic learnWe;
	logic daHit;
	logic [1:0] daPort;
	logic saHit;
	logic [DYN_ENTRY_W-1:0] dynEntry;
	logic [DYN_IDX_W-1:0] cntM1;
	logic dynEmpty;
	logic [31:0] ageCntQ;
	logic [1:0] ageEpochQ;
	logic [11:0] vidAssigned;
	logic vHit;
	logic [3:0] vFid;
	logic [2:0] vMember;
	logic aValidQ;
	logic aDropQ;
	logic [3:0] aFidQ;
	logic [2:0] aMemberQ;
	logic [1:0] aPortQ;
	logic [47:0] aDaQ;
	logic [47:0] aSaQ;
	logic sHit;
	logic [2:0] sFwd;
	logic [2:0] ingressMask;

	// Index decode: word aligned, upper bits beyond the index zero
	function automatic logic isMapped(input logic [ADDR_W-1:0] a);
		logic [7:0] i;
		i = a[9:2];
		return a[1:0] == 2'b00 && a[ADDR_W-1:10] == '0 &&
			(i == IDX_GCFG || (i >= IDX_CTRL0 && i <= IDX_DATA_LO) ||
			(i >= IDX_PVID0 && i < IDX_PVID0 + 8'(NUM_PORTS)));
	endfunction : isMapped

	assign wIdx = awAddrQ[9:2];
	assign wMapped = isMapped(awAddrQ);
	assign rIdx = araddr[9:2];
	assign rMapped = isMapped(araddr);
	assign wrDo = awHeldQ && wHeldQ && !bvalid;
	// Only the address-low write launches a table command
	assign trig = wrDo && wMapped && wIdx == IDX_CTRL1 && wStrbQ[0];
	assign cmdAddr = {ctrl0Q[1:0], wDataQ[7:0]};
	assign cmdSel = table_sel_t'(ctrl0Q[CTRL_SEL_LSB +: 2]);
	assign cmdRead = ctrl0Q[CTRL_DIR_BIT];

	// Write address and data are taken in either order
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			awHeldQ <= 1'b0;
			wHeldQ <= 1'b0;
			awready <= 1'b1;
			wready <= 1'b1;
			bvalid <= 1'b0;
			bresp <= RESP_OKAY;
			awAddrQ <= '0;
			wDataQ <= '0;
			wStrbQ <= '0;
		end else begin
			if (awvalid && awready) begin
				awHeldQ <= 1'b1;
				awAddrQ <= awaddr;
				awready <= 1'b0;
			end
			if (wvalid && wready) begin
				wHeldQ <= 1'b1;
				wDataQ <= wdata;
				wStrbQ <= wstrb;
				wready <= 1'b0;
			end
			if (wrDo) begin
				bvalid <= 1'b1;
				bresp <= wMapped ? RESP_OKAY : RESP_SLVERR;
			end
			if (bvalid && bready) begin
				bvalid <= 1'b0;
				awHeldQ <= 1'b0;
				wHeldQ <= 1'b0;
				awready <= 1'b1;
				wready <= 1'b1;
			end
		end
	end

	always_comb begin
		rWord = '0;
		if (rIdx == IDX_GCFG) begin
			rWord[7:0] = gcfgQ;
		end else if (rIdx == IDX_CTRL0) begin
			rWord[7:0] = ctrl0Q;
		end else if (rIdx == IDX_CTRL1) begin
			rWord[7:0] = ctrl1Q;
		end else if (rIdx >= IDX_DATA_HI && rIdx <= IDX_DATA_LO) begin
			for (int b = 0; b < DATA_BYTES; b++) begin
				if (rIdx == IDX_DATA_LO - 8'(b)) begin
					rWord[7:0] = dataQ[b*8 +: 8];
				end
			end
		end else begin
			for (int p = 0; p < NUM_PORTS; p++) begin
				if (rIdx == IDX_PVID0 + 8'(p)) begin
					rWord[11:0] = pvidQ[p];
				end
			end
		end
	end

	// Read answers one cycle after the address is taken
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			arready <= 1'b1;
			rvalid <= 1'b0;
			rdata <= '0;
			rresp <= RESP_OKAY;
		end else if (arvalid && arready) begin
			arready <= 1'b0;
			rvalid <= 1'b1;
			rdata <= rMapped ? rWord : '0;
			rresp <= rMapped ? RESP_OKAY : RESP_SLVERR;
		end else if (rvalid && rready) begin
			rvalid <= 1'b0;
			arready <= 1'b1;
		end
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			gcfgQ <= GCFG_RESET;
			ctrl0Q <= '0;
			ctrl1Q <= '0;
			for (int p = 0; p < NUM_PORTS; p++) begin
				pvidQ[p] <= PVID_RESET;
			end
		end else if (wrDo && wMapped) begin
			if (wStrbQ[0] && wIdx == IDX_GCFG) begin
				gcfgQ <= wDataQ[7:0];
			end
			if (wStrbQ[0] && wIdx == IDX_CTRL0) begin
				ctrl0Q <= wDataQ[7:0];
			end
			if (wStrbQ[0] && wIdx == IDX_CTRL1) begin
				ctrl1Q <= wDataQ[7:0];
			end
			for (int p = 0; p < NUM_PORTS; p++) begin
				if (wIdx == IDX_PVID0 + 8'(p)) begin
					if (wStrbQ[0]) begin
						pvidQ[p][7:0] <= wDataQ[7:0];
					end
					if (wStrbQ[1]) begin
						pvidQ[p][11:8] <= wDataQ[11:8];
					end
				end
			end
		end
	end

	// Data bytes change only on a command or a processor write
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			dataQ <= '0;
		end else if (trig && cmdRead) begin
			unique case (cmdSel)
				TBL_STATIC: dataQ <= {14'h0000, staticQ[cmdAddr[2:0]]};
				TBL_VLAN: dataQ <= {52'h0, vlanQ[cmdAddr[3:0]]};
				TBL_DYNAMIC: dataQ[DYN_NOTREADY_BIT] <= 1'b1;
				TBL_MIB: dataQ <= '0;
			endcase
		end else if (dynPendQ && !learnWe) begin
			dataQ <= {1'b0, 4'h0, dynEmpty, cntM1, dynEntry};
		end else if (wrDo && wMapped && wStrbQ[0]) begin
			for (int b = 0; b < DATA_BYTES; b++) begin
				if (wIdx == IDX_DATA_LO - 8'(b)) begin
					dataQ[b*8 +: 8] <= wDataQ[7:0];
				end
			end
		end
	end

	// Not ready while the learner owns the table; a new dynamic read wins
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			dynPendQ <= 1'b0;
			dynIdxQ <= '0;
		end else if (trig && cmdRead && cmdSel == TBL_DYNAMIC) begin
			dynPendQ <= 1'b1;
			dynIdxQ <= DYN_IDX_W'(cmdAddr);
		end else if (!learnWe) begin
			dynPendQ <= 1'b0;
		end
	end

	// Dynamic-table writes fall through: it is learner-owned
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			for (int v = 0; v < VLAN_N; v++) begin
				vlanQ[v] <= VLAN_RESET;
			end
			for (int s = 0; s < STATIC_N; s++) begin
				staticQ[s] <= '0;
			end
		end else if (trig && !cmdRead) begin
			if (cmdSel == TBL_STATIC) begin
				staticQ[cmdAddr[2:0]] <= dataQ[STATIC_W-1:0];
			end else if (cmdSel == TBL_VLAN) begin
				vlanQ[cmdAddr[3:0]] <= dataQ[VLAN_W-1:0];
			end
		end
	end

	// Time stamp epoch for learned entries
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			ageCntQ <= '0;
			ageEpochQ <= '0;
		end else if (ageCntQ == 32'(AGE_CYCLES - 1)) begin
			ageCntQ <= '0;
			ageEpochQ <= ageEpochQ + 1'b1;
		end else begin
			ageCntQ <= ageCntQ + 1'b1;
		end
	end

	// Stage A: VID assignment and VLAN table search
	always_comb begin
		vidAssigned = pktVid;
		if (!pktTagged || pktVid == 12'h000) begin
			vidAssigned = pvidQ[pktPort > 2'd2 ? 2'd2 : pktPort];
		end
		vHit = 1'b0;
		vFid = '0;
		vMember = '1;
		if (gcfgQ[VLAN_EN_BIT]) begin
			for (int v = VLAN_N - 1; v >= 0; v--) begin
				if (vlanQ[v][VLAN_VALID_BIT] && vlanQ[v][11:0] == vidAssigned) begin
					vHit = 1'b1;
					vFid = vlanQ[v][VLAN_FID_LSB +: 4];
					vMember = vlanQ[v][VLAN_MEMBER_LSB +: 3];
				end
			end
		end else begin
			vHit = 1'b1;
		end
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			aValidQ <= 1'b0;
			aDropQ <= 1'b0;
			aFidQ <= '0;
			aMemberQ <= '0;
			aPortQ <= '0;
			aDaQ <= '0;
			aSaQ <= '0;
		end else begin
			aValidQ <= pktValid;
			aDropQ <= !vHit;
			aFidQ <= vFid;
			aMemberQ <= vMember;
			aPortQ <= pktPort;
			aDaQ <= pktDa;
			aSaQ <= pktSa;
		end
	end

	// Stage B: static and dynamic DA lookup, SA learning
	always_comb begin
		sHit = 1'b0;
		sFwd = '0;
		for (int s = STATIC_N - 1; s >= 0; s--) begin
			if (staticQ[s][STATIC_VALID_BIT] && staticQ[s][47:0] == aDaQ &&
				(!staticQ[s][STATIC_USEFID_BIT] ||
				staticQ[s][STATIC_FID_LSB +: 4] == aFidQ)) begin
				sHit = 1'b1;
				sFwd = staticQ[s][STATIC_FWD_LSB +: 3];
			end
		end
	end

	assign ingressMask = 3'b001 << aPortQ;
	assign learnWe = aValidQ && !aDropQ && !saHit;

	dyn_mac_table #(
		.IDX_W(DYN_IDX_W)
	) dynTable (
		.mclk(mclk),
		.rst_b(rst_b),
		.daKey({aFidQ, aDaQ}),
		.saKey({aFidQ, aSaQ}),
		.daHit(daHit),
		.daPort(daPort),
		.saHit(saHit),
		.learnWe(learnWe),
		.learnPort(aPortQ),
		.learnTs(ageEpochQ),
		.rdIdx(dynIdxQ),
		.rdEntry(dynEntry),
		.countMinusOne(cntM1),
		.empty(dynEmpty)
	);

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			fwdValid <= 1'b0;
			fwdDrop <= 1'b0;
			fwdPorts <= '0;
		end else begin
			fwdValid <= aValidQ;
			fwdDrop <= aValidQ && aDropQ;
			if (aDropQ) begin
				fwdPorts <= '0;
			end else if (sHit) begin
				fwdPorts <= sFwd & ~ingressMask;
			end else if (daHit) begin
				fwdPorts <= (3'b001 << daPort) & ~ingressMask;
			end else begin
				fwdPorts <= aMemberQ & ~ingressMask;
			end
		end
	end
endmodule : switch_lookup_table_access

// ### rtl/switch_lut_pkg.sv
package switch_lut_pkg;
	// Register indices; byte address is four times the index
	localparam logic [7:0] IDX_GCFG = 8'h05;
	localparam logic [7:0] IDX_CTRL0 = 8'h6E;
	localparam logic [7:0] IDX_CTRL1 = 8'h6F;
	localparam logic [7:0] IDX_DATA_HI = 8'h70;
	localparam logic [7:0] IDX_DATA_LO = 8'h78;
	localparam logic [7:0] IDX_PVID0 = 8'h80;
	localparam int NUM_PORTS = 3;
	localparam int DATA_BYTES = 9;
	localparam int VLAN_EN_BIT = 7;
	localparam int CTRL_DIR_BIT = 4;
	localparam int CTRL_SEL_LSB = 2;
	localparam logic [7:0] GCFG_RESET = 8'h00;
	localparam logic [11:0] PVID_RESET = 12'h001;
	typedef enum logic [1:0] {
		TBL_STATIC = 2'b00,
		TBL_VLAN = 2'b01,
		TBL_DYNAMIC = 2'b10,
		TBL_MIB = 2'b11
	} table_sel_t;
	// VLAN entry layout
	localparam int VLAN_W = 20;
	localparam int VLAN_VALID_BIT = 19;
	localparam int VLAN_MEMBER_LSB = 16;
	localparam int VLAN_FID_LSB = 12;
	localparam logic [19:0] VLAN_RESET = 20'hF0001;
	// Static entry layout
	localparam int STATIC_W = 58;
	localparam int STATIC_FID_LSB = 54;
	localparam int STATIC_USEFID_BIT = 53;
	localparam int STATIC_VALID_BIT = 51;
	localparam int STATIC_FWD_LSB = 48;
	// Dynamic entry layout as read back
	localparam int DYN_ENTRY_W = 56;
	localparam int DYN_NOTREADY_BIT = 71;
	localparam int DYN_EMPTY_BIT = 66;
	localparam int DYN_COUNT_LSB = 56;
	localparam int DYN_TS_LSB = 54;
	localparam int DYN_PORT_LSB = 52;
	localparam int DYN_FID_LSB = 48;
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage : switch_lut_pkg

// ### verif/lut_access_checker.sv
module lut_access_checker (
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic awvalid,
	input wire logic awready,
	input wire logic wvalid,
	input wire logic wready,
	input wire logic bvalid,
	input wire logic bready,
	input wire logic arvalid,
	input wire logic arready,
	input wire logic rvalid,
	input wire logic rready,
	input wire logic [31:0] rdata,
	input wire logic pktValid,
	input wire logic [1:0] pktPort,
	input wire logic fwdValid,
	input wire logic fwdDrop,
	input wire logic [2:0] fwdPorts
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rst_b);
	sequence wrTaken;
		awvalid && awready && wvalid && wready;
	endsequence
	sequence pktIn;
		pktValid && pktPort != 2'h3;
	endsequence
	wr_answer_a: assert property (wrTaken |=> !awready ##1 bvalid)
		else $error("no write response");
	b_hold_a: assert property (bvalid && !bready |=> bvalid)
		else $error("write response dropped");
	rd_answer_a: assert property (arvalid && arready |=> rvalid && !arready)
		else $error("no read response");
	r_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
		else $error("read data changed while waiting");
	fwd_latency_a: assert property (pktValid |-> ##2 fwdValid)
		else $error("no forwarding result");
	fwd_cause_a: assert property (fwdValid |-> $past(pktValid, 2))
		else $error("forwarding result without packet");
	ingress_mask_a: assert property (pktIn |-> ##2
		fwdPorts[$past(pktPort, 2)] == 1'b0)
		else $error("ingress port in forwarding mask");
	drop_empty_a: assert property (fwdValid && fwdDrop |-> fwdPorts == 3'h0)
		else $error("dropped packet still forwarded");
endmodule : lut_access_checker

bind switch_lookup_table_access lut_access_checker chk (.mclk, .rst_b,
	.awvalid, .awready, .wvalid, .wready, .bvalid, .bready, .arvalid,
	.arready, .rvalid, .rready, .rdata, .pktValid, .pktPort, .fwdValid,
	.fwdDrop, .fwdPorts);

// ### verif/mgmt_cpu_model.sv
module mgmt_cpu_model import switch_lut_pkg::*; (
	input wire logic mclk,
	output logic awvalid,
	output logic [11:0] awaddr,
	input wire logic awready,
	output logic wvalid,
	output logic [31:0] wdata,
	output logic [3:0] wstrb,
	input wire logic wready,
	input wire logic bvalid,
	input wire logic [1:0] bresp,
	output logic bready,
	output logic arvalid,
	output logic [11:0] araddr,
	input wire logic arready,
	input wire logic rvalid,
	input wire logic [31:0] rdata,
	input wire logic [1:0] rresp,
	output logic rready,
	output logic hung
);
	timeunit 1ns;
	timeprecision 1ps;
	// Starts at a code the block never answers, so a stale value shows
	logic [1:0] wrResp = 2'h1;
	initial begin
		{awvalid, wvalid, bready, arvalid, rready, hung} = '0;
		{awaddr, araddr, wdata} = '0;
		wstrb = 4'h1;
	end
	// Released lines show inverted values, never the stale ones
	task automatic wr(input logic [7:0] idx, input logic [7:0] v);
		int n;
		@(posedge mclk);
		awaddr <= {2'h0, idx, 2'h0};
		wdata <= {24'h0, v};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (n = 0; n < 64; n++) begin
			@(posedge mclk);
			if (awvalid && awready) begin
				awvalid <= 1'b0;
				awaddr <= ~awaddr;
			end
			if (wvalid && wready) begin
				wvalid <= 1'b0;
				wdata <= ~wdata;
			end
			if (bvalid && bready) begin
				wrResp = bresp;
				break;
			end
		end
		bready <= 1'b0;
		if (n == 64)
			hung <= 1'b1;
	endtask : wr
	// Random lag on rready exercises a slow master
	task automatic rd(input logic [7:0] idx, output logic [31:0] v,
		output logic [1:0] resp);
		int n;
		int lag;
		lag = $urandom_range(2);
		@(posedge mclk);
		araddr <= {2'h0, idx, 2'h0};
		arvalid <= 1'b1;
		for (n = 0; n < 64; n++) begin
			@(posedge mclk);
			if (arvalid && arready) begin
				arvalid <= 1'b0;
				araddr <= ~araddr;
			end
			if (rvalid && rready)
				break;
			if (n >= lag)
				rready <= 1'b1;
		end
		v = rdata;
		resp = rresp;
		rready <= 1'b0;
		if (n == 64)
			hung <= 1'b1;
	endtask : rd
	task automatic cmd(input logic rdDir, input table_sel_t t,
		input logic [9:0] idx);
		wr(IDX_CTRL0, {3'h0, rdDir, t, idx[9:8]});
		wr(IDX_CTRL1, idx[7:0]);
	endtask : cmd
	task automatic dynHead(output logic [31:0] v);
		logic [1:0] r;
		int n;
		for (n = 0; n < 8; n++) begin
			rd(IDX_DATA_HI, v, r);
			if (!v[7])
				break;
		end
		if (n == 8)
			hung <= 1'b1;
	endtask : dynHead
endmodule : mgmt_cpu_model

// ### verif/switch_lookup_table_access_tb.sv
module switch_lookup_table_access_tb import switch_lut_pkg::*; ;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [47:0] MACB = 48'h0A1B_2C3D_4E00;
	logic mclk = 1'b0;
	logic rst_b = 1'b0;
	logic awvalid, awready, wvalid, wready, bvalid, bready, hung;
	logic arvalid, arready, rvalid, rready, fwdValid, fwdDrop;
	logic [11:0] awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp;
	logic [2:0] fwdPorts;
	logic pktValid = 1'b0;
	logic pktTagged = 1'b0;
	logic [1:0] pktPort = 2'h0;
	logic [11:0] pktVid = 12'h000;
	logic [47:0] pktDa = '0;
	logic [47:0] pktSa = '0;
	int error_cnt = 0;
	int check_count = 0;
	int vt[16];
	int pvid[3] = '{1, 1, 1};
	int dyn[bit [51:0]];
	bit vlanOn = 1'b0;
	always #2.5 mclk = ~mclk;
	switch_lookup_table_access #(.AGE_CYCLES(16)) dut (.mclk, .rst_b,
		.awvalid, .awaddr, .awready, .wvalid, .wdata, .wstrb, .wready,
		.bvalid, .bresp, .bready, .arvalid, .araddr, .arready, .rvalid,
		.rdata, .rresp, .rready, .pktValid, .pktPort, .pktTagged, .pktVid,
		.pktDa, .pktSa, .fwdValid, .fwdDrop, .fwdPorts);
	mgmt_cpu_model cpu (.mclk, .awvalid, .awaddr, .awready, .wvalid, .wdata,
		.wstrb, .wready, .bvalid, .bready, .arvalid, .araddr, .arready,
		.rvalid, .rdata, .rresp, .rready, .hung, .bresp);
	task automatic report_and_stop();
		$display("checks %0d errors %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : report_and_stop
	task automatic check(input logic [71:0] seen, input logic [71:0] exp);
		check_count++;
		if (seen !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: got %h want %h", $time, seen, exp);
		end
	endtask : check
	always @(posedge hung) begin
		error_cnt++;
		report_and_stop();
	end
	// Bench copy of the learner's XOR fold of {group, MAC} to a row
	function automatic logic [9:0] foldIdx(input logic [51:0] k);
		logic [9:0] h;
		h = '0;
		for (int i = 0; i < 52; i++)
			h[i % 10] = h[i % 10] ^ k[i];
		return h;
	endfunction : foldIdx
	task automatic tblWr(input table_sel_t t, input int i,
		input logic [71:0] v);
		for (int k = 0; k < DATA_BYTES; k++)
			cpu.wr(IDX_DATA_HI + 8'(k), v[71 - 8 * k -: 8]);
		cpu.cmd(1'b0, t, 10'(i));
	endtask : tblWr
	task automatic tblRd(input table_sel_t t, input int i,
		output logic [71:0] v);
		logic [31:0] b;
		logic [1:0] r;
		cpu.cmd(1'b1, t, 10'(i));
		for (int k = 0; k < DATA_BYTES; k++) begin
			cpu.rd(IDX_DATA_HI + 8'(k), b, r);
			v[71 - 8 * k -: 8] = b[7:0];
		end
	endtask : tblRd
	task automatic dynCount();
		logic [31:0] h, b;
		logic [1:0] r;
		logic [9:0] c;
		c = 10'(dyn.num() ? dyn.num() - 1 : 0);
		cpu.cmd(1'b1, TBL_DYNAMIC, 10'h0);
		cpu.dynHead(h);
		cpu.rd(IDX_DATA_HI + 8'h1, b, r);
		check({h, b}, {29'h0, dyn.num() == 0, c[9:8], 24'h0, c[7:0]});
	endtask : dynCount
	// Sources stay on one port so learning never migrates
	task automatic pkt(input int p, input int di, input int vid, input bit tg);
		int v2, e, ports;
		bit [3:0] filter_group_id;
		bit drop;
		bit [47:0] da, sa;
		da = MACB + 48'(di << 4);
		sa = MACB + 48'((p + 1 + 3 * $urandom_range(1)) << 4);
		v2 = (tg && vid != 0) ? vid : pvid[p];
		e = -1;
		for (int i = 15; i >= 0; i--)
			if (vt[i][19] && vt[i][11:0] == v2)
				e = i;
		drop = vlanOn && e < 0;
		filter_group_id = (vlanOn && !drop) ? vt[e][15:12] : 4'h0;
		ports = (vlanOn && !drop) ? vt[e][18:16] : 7;
		if (dyn.exists({filter_group_id, da}))
			ports = 1 << dyn[{filter_group_id, da}];
		ports = drop ? 0 : ports & ~(1 << p);
		if (!drop && !dyn.exists({filter_group_id, sa}))
			dyn[{filter_group_id, sa}] = p;
		@(posedge mclk);
		pktValid <= 1'b1;
		pktPort <= 2'(p);
		pktTagged <= tg;
		pktVid <= 12'(vid);
		pktDa <= da;
		pktSa <= sa;
		@(posedge mclk);
		pktValid <= 1'b0;
		@(posedge mclk);
		#1;
		check({fwdValid, fwdDrop, fwdPorts}, {1'b1, drop, 3'(ports)});
	endtask : pkt
	initial begin
		logic [71:0] v, s;
		logic [31:0] b;
		logic [1:0] r;
		int wl[3] = '{6, 3, 15};
		int vids[5] = '{0, 1, 5, 7, 9};
		void'($urandom(32'hEE3680DA));
		foreach (vt[i])
			vt[i] = VLAN_RESET;
		repeat (12) @(posedge mclk);
		rst_b <= 1'b1;
		cpu.rd(IDX_GCFG, b, r);
		check({r, b}, {RESP_OKAY, 24'h0, GCFG_RESET});
		cpu.rd(8'h79, b, r);
		check({r, b}, {RESP_SLVERR, 32'h0});
		cpu.wr(IDX_DATA_LO, 8'hA5);
		check(cpu.wrResp, RESP_OKAY);
		cpu.wr(8'h79, 8'h5A);
		check(cpu.wrResp, RESP_SLVERR);
		cpu.rd(IDX_DATA_LO, b, r);
		check(b, 32'hA5);
		tblRd(TBL_VLAN, $urandom_range(15), v);
		check(v, 72'(VLAN_RESET));
		vt[6] = 'hD2005;
		vt[3] = 'h63007;
		vt[15] = $urandom_range(32'hFFFFF);
		foreach (wl[k])
			tblWr(TBL_VLAN, wl[k], 72'(vt[wl[k]]));
		foreach (wl[k]) begin
			tblRd(TBL_VLAN, wl[k], v);
			check(v, 72'(vt[wl[k]]));
		end
		cpu.rd(IDX_DATA_LO, b, r);
		check(b, 32'(vt[15][7:0]));
		s = 72'({$urandom, $urandom, $urandom});
		tblWr(TBL_STATIC, 7, s);
		tblRd(TBL_STATIC, 0, v);
		check(v, 72'h0);
		tblRd(TBL_STATIC, 7, v);
		check(v, s & 72'h3FF_FFFF_FFFF_FFFF);
		tblRd(TBL_MIB, 1, v);
		check(v, 72'h0);
		dynCount();
		repeat (12)
			pkt($urandom_range(2), $urandom_range(6), $urandom_range(4095),
				1'($urandom_range(1)));
		cpu.wr(IDX_GCFG, 8'h80);
		cpu.wr(IDX_PVID0, 8'h05);
		vlanOn = 1'b1;
		pvid[0] = 5;
		repeat (30)
			pkt($urandom_range(2), $urandom_range(6), vids[$urandom_range(4)],
				1'($urandom_range(1)));
		tblWr(TBL_DYNAMIC, 0, '1);
		dynCount();
		foreach (dyn[k]) begin
			tblRd(TBL_DYNAMIC, int'(foldIdx(k)), v);
			check({v[71], v[66], v[53:0]}, {2'b00, 2'(dyn[k]), k});
		end
		report_and_stop();
	end
endmodule : switch_lookup_table_access_tb
